// [dfu_top.sv]
// Digital I/O function unit: special-function inputs and mode-driven outputs.
// Assumes an Avalon-MM master on sys_clk, field pins asynchronous to it,
// and alarm flags, tracked values and count increments from sys_clk logic.
// Notes on behaviour
// [RQ1] Each special input launches up to three actions: tap, 5 s hold, 15 s hold.
// [RQ2] Tap mapped to display advance steps the display once per tap.
// [RQ3] Flow-run reset clears grand total of run 1, run 2 or both.
// [RQ4] Pulse-input reset clears the selected grand totals of inputs 1 to 3.
// [RQ5] Unlatch action releases the latch of selected channels 1 to 6.
// [RQ6] Archive release, publish, partial record, alarm acknowledge fire once per activation.
// [RQ7] Abort forces any running logic program to abort immediately.
// [RQ8] Program reset restarts the program, also from abort or fail.
// [RQ9] Count mode pulses once per scaling quantity, each pulse width ms long.
// [RQ10] Periodic mode repeats pulses at the period with separate width.
// [RQ11] Inactive output rests in its normal position; active drives the opposite.
// [RQ12] Alarm output takes a mask of up to 32 alarms.
// [RQ13] Alarm output activates on ANY selected alarm or on ALL together.
// [RQ14] Hold-off delays activation until the alarm persisted for that time.
// [RQ15] Latched output stays active after the cause ends until cleared.
// [RQ16] Unlatched output drops as soon as the condition returns to normal.
// [RQ17] Latch clear exists per channel and for all channels at once.
// [RQ18] Conditional mode compares below low, above high, or outside the range.
// [RQ19] Each output reports active state, and latched ones their latch state.
// [RQ20] Input polarity selects the asserted level; a fitted switch uses high.
// [RQ21] Hold measured from assertion, classed on release: under 5 s, 5 s, 15 s.
// [RQ22] Count mode keeps its remainder and queues pulses so none are lost.
`timescale 1ns/1ps
`include "dfu_defines.svh"
module dfu_top #(
   parameter int N_CH = `DFU_N_CH,
   parameter int CYC_PER_MS = `DFU_MS_NS / `DFU_CLK_PERIOD_NS,
   parameter logic [15:0] HOLD5_MS = `DFU_HOLD5_MS,
   parameter logic [15:0] HOLD15_MS = `DFU_HOLD15_MS
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [N_CH-1:0] chan_pin_in,
   output logic [N_CH-1:0] chan_pin_out,
   output logic [N_CH-1:0] chan_pin_oe,
   input wire logic [`DFU_ALM_W-1:0] alarm_flags,
   input wire logic [N_CH-1:0][31:0] track_value,
   input wire logic [N_CH-1:0][31:0] accum_add,
   input wire logic [N_CH-1:0] accum_valid,
   output dfu_pkg::dfu_action_s actions
);
   import dfu_pkg::*;
   localparam int TW = $clog2(CYC_PER_MS + 1);

   // Refuse sizes the unlatch field and tick counter cannot serve
   if (N_CH < 1 || N_CH > 6) begin : g_bad_nch
      $error("N_CH must lie in 1..6");
   end
   if (CYC_PER_MS < 1 || HOLD5_MS >= HOLD15_MS) begin : g_bad_time
      $error("tick count or hold thresholds invalid");
   end

   // Byte-lane merge of a register write
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Channel window hit: window c sits at 0x40*(c+1)
   function automatic logic win_hit(input logic [8:0] a);
      return (a[8:6] != 3'h0) && ({29'h0, a[8:6]} <= N_CH);
   endfunction

   logic [31:0] rf_reg [N_CH][10];
   logic [N_CH-1:0] sync1_reg, sync2_reg;
   logic [TW-1:0] tick_cnt_reg;
   logic ms_tick_reg;
   logic [15:0] hold_reg [N_CH];
   logic [N_CH-1:0] prev_reg;
   logic [2:0] ev_reg [N_CH];
   logic done_reg;
   logic [31:0] rd_word, rd_data_reg;
   dfu_action_s act_next, act_reg;
   dfu_act_e code;
   logic [31:0] sel;
   logic [N_CH-1:0] pressed, lvl, pg_pulse, ac_active, ac_latch, chan_active, clr;
   logic [N_CH-1:0][15:0] pending;
   dfu_chcfg_s cfg [N_CH];

   // Bus decode; each access waits exactly one cycle
   wire logic req = avs_read || avs_write;
   wire logic wr_go = avs_write && done_reg;
   wire logic hit = win_hit(avs_address);
   wire logic [2:0] ch_sel = avs_address[8:6] - 3'h1;
   wire logic [3:0] idx = avs_address[5:2];
   wire logic cmd_go = wr_go && (avs_address == `DFU_CMD_OFS);
   assign avs_waitrequest = req && !done_reg;
   assign avs_readdata = rd_data_reg;

   // Two-stage synchroniser for the field pins
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= chan_pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Millisecond time base for all hold, width and period counts
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_reg <= '0;
         ms_tick_reg <= 1'b0;
      end else begin
         ms_tick_reg <= (tick_cnt_reg == TW'(CYC_PER_MS - 1));
         tick_cnt_reg <= (tick_cnt_reg == TW'(CYC_PER_MS - 1)) ? '0 : tick_cnt_reg + TW'(1);
      end
   end

   // Per-channel configuration view, pins of conditions and outputs
   for (genvar c = 0; c < N_CH; c++) begin : g_ch
      wire logic [31:0] cw = rf_reg[c][`DFU_R_CFG];
      assign cfg[c].mode = dfu_mode_e'(cw[2:0]);
      assign cfg[c].nc = cw[`DFU_CFG_NC];
      assign cfg[c].latch_en = cw[`DFU_CFG_LATCH];
      assign cfg[c].all_mode = cw[`DFU_CFG_ALL];
      assign cfg[c].width_ms = rf_reg[c][`DFU_R_WIDTH][15:0];
      assign cfg[c].period_ms = rf_reg[c][`DFU_R_PERIOD][15:0];
      assign cfg[c].holdoff_ms = rf_reg[c][`DFU_R_HOLDOFF][15:0];
      assign cfg[c].scale = rf_reg[c][`DFU_R_SCALE];
      assign cfg[c].mask = rf_reg[c][`DFU_R_MASK];
      assign cfg[c].sp_lo = rf_reg[c][`DFU_R_SPLO];
      assign cfg[c].sp_hi = rf_reg[c][`DFU_R_SPHI];
      // A fitted switch ignores the low-polarity setting
      assign lvl[c] = sync2_reg[c] ^ (cw[`DFU_CFG_TLOW] && !cw[`DFU_CFG_SWITCH]); // RQ20
      assign pressed[c] = lvl[c] && (cfg[c].mode == MODE_SPECIAL);
      // Clear from one channel, all channels, or an unlatch action
      assign clr[c] = (cmd_go && (avs_writedata[c] || avs_writedata[`DFU_CMD_ALL])) || act_reg.unlatch[c]; // RQ17 RQ5
      // Pulse modes follow the generator, others the condition
      assign chan_active[c] = (cfg[c].mode == MODE_ACCUM || cfg[c].mode == MODE_PERIODIC) ? pg_pulse[c] : ac_active[c];

      dfu_pulse_gen u_pgen (
         .sys_clk(sys_clk),
         .resetn(resetn),
         .cfg(cfg[c]),
         .ms_tick(ms_tick_reg),
         .accum_add(accum_add[c]),
         .accum_valid(accum_valid[c]),
         .pulse(pg_pulse[c]),
         .pending(pending[c])
      );
      dfu_alarm_cond u_cond (
         .sys_clk(sys_clk),
         .resetn(resetn),
         .cfg(cfg[c]),
         .ms_tick(ms_tick_reg),
         .alarms(alarm_flags),
         .value(track_value[c]),
         .clr(clr[c]),
         .active(ac_active[c]),
         .latched(ac_latch[c])
      );

      chk_tap_class: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ21
         prev_reg[c] && !pressed[c] && hold_reg[c] < HOLD5_MS |=> ev_reg[c] == 3'b001)
         else $error("short hold not classed as tap");
      chk_display_step: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ2
         ev_reg[c][0] && rf_reg[c][`DFU_R_SFMAP][3:0] == ACT_ADV |=> act_reg.disp_adv)
         else $error("tap did not step the display");
      chk_abort_now: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ7
         ev_reg[c][1] && rf_reg[c][`DFU_R_SFMAP][7:4] == ACT_ABORT |=> act_reg.prog_abort)
         else $error("abort action not issued");
      chk_flow_select: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ3
         ev_reg[c][2] && rf_reg[c][`DFU_R_SFMAP][11:8] == ACT_FLOW |=>
         (act_reg.flow_reset & $past(rf_reg[c][`DFU_R_SFSEL][1:0])) == $past(rf_reg[c][`DFU_R_SFSEL][1:0]))
         else $error("selected flow run total not reset");
      chk_rest_level: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ11
         cfg[c].mode >= MODE_ACCUM && !chan_active[c] && cfg[c].mode == $past(cfg[c].mode) |=>
         chan_pin_oe[c] && chan_pin_out[c] == $past(cfg[c].nc))
         else $error("inactive output not in normal position");
   end

   // Hold timing from the asserting edge, classed at release
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prev_reg <= '0;
         for (int c = 0; c < N_CH; c++) begin
            hold_reg[c] <= 16'h0;
            ev_reg[c] <= 3'h0;
         end
      end else begin
         prev_reg <= pressed;
         for (int c = 0; c < N_CH; c++) begin
            if (pressed[c] && !prev_reg[c]) begin
               hold_reg[c] <= 16'h0; // RQ21
            end else if (pressed[c] && ms_tick_reg && hold_reg[c] < HOLD15_MS) begin
               hold_reg[c] <= hold_reg[c] + 16'h1;
            end
            ev_reg[c][0] <= prev_reg[c] && !pressed[c] && hold_reg[c] < HOLD5_MS; // RQ1
            ev_reg[c][1] <= prev_reg[c] && !pressed[c] && hold_reg[c] >= HOLD5_MS && hold_reg[c] < HOLD15_MS;
            ev_reg[c][2] <= prev_reg[c] && !pressed[c] && hold_reg[c] >= HOLD15_MS;
         end
      end
   end

   // Action dispatch: each duration class has its own 4-bit code
   always_comb begin
      act_next = '0;
      code = ACT_NONE;
      sel = 32'h0;
      for (int c = 0; c < N_CH; c++) begin
         for (int k = 0; k < 3; k++) begin
            code = dfu_act_e'(rf_reg[c][`DFU_R_SFMAP][4*k +: 4]);
            sel = rf_reg[c][`DFU_R_SFSEL];
            if (ev_reg[c][k]) begin
               case (code)
                  ACT_ADV: act_next.disp_adv = 1'b1; // RQ2
                  ACT_FLOW: act_next.flow_reset = act_next.flow_reset | sel[1:0]; // RQ3
                  ACT_PULSE: act_next.pulse_reset = act_next.pulse_reset | sel[4:2]; // RQ4
                  ACT_UNLATCH: act_next.unlatch = act_next.unlatch | sel[10:5]; // RQ5
                  ACT_ARCH_REL: act_next.arch_release = 1'b1; // RQ6
                  ACT_ARCH_PUB: act_next.arch_publish = 1'b1; // RQ6
                  ACT_ARCH_PART: act_next.arch_partial = 1'b1; // RQ6
                  ACT_ALM_ACK: act_next.alarm_ack = 1'b1; // RQ6
                  ACT_ABORT: act_next.prog_abort = 1'b1; // RQ7
                  ACT_PROG_RST: act_next.prog_reset = 1'b1; // RQ8
                  default: ;
               endcase
            end
         end
      end
   end

   // Actions are one-cycle pulses from flops; outputs drive only in output modes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         act_reg <= '0;
         chan_pin_out <= '0;
         chan_pin_oe <= '0;
      end else begin
         act_reg <= act_next;
         for (int c = 0; c < N_CH; c++) begin
            chan_pin_oe[c] <= (cfg[c].mode >= MODE_ACCUM);
            chan_pin_out[c] <= (cfg[c].mode >= MODE_ACCUM) && (chan_active[c] ^ cfg[c].nc); // RQ11
         end
      end
   end
   assign actions = act_reg;

   // Read mux: status words report output and latch state
   always_comb begin
      rd_word = 32'h0;
      if (avs_address == `DFU_STATUS_OFS) begin
         rd_word[5:0] = 6'(chan_active); // RQ19
         rd_word[13:8] = 6'(ac_latch);
         rd_word[21:16] = 6'(lvl);
      end else if (hit && idx < `DFU_N_REGS) begin
         rd_word = rf_reg[ch_sel][idx];
      end else if (hit && idx == `DFU_R_STAT) begin
         rd_word = {pending[ch_sel], 14'h0, ac_latch[ch_sel], chan_active[ch_sel]}; // RQ19
      end
   end

   // Bus handshake and register writes; unmapped writes are dropped
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         done_reg <= 1'b0;
         rd_data_reg <= 32'h0;
         for (int c = 0; c < N_CH; c++) begin
            for (int r = 0; r < 10; r++) begin
               rf_reg[c][r] <= 32'h0;
            end
         end
      end else begin
         done_reg <= req && !done_reg;
         if (avs_read && !done_reg) begin
            rd_data_reg <= rd_word;
         end
         for (int c = 0; c < N_CH; c++) begin
            for (int r = 0; r < 10; r++) begin
               if (wr_go && hit && ch_sel == 3'(c) && idx == 4'(r)) begin
                  rf_reg[c][r] <= be_merge(rf_reg[c][r], avs_writedata, avs_byteenable);
               end
            end
         end
      end
   end

   chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
      req && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");
   chk_one_shot: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ6
      ev_reg[0] != 3'h0 |=> ev_reg[0] == 3'h0)
      else $error("trigger event repeated without new activation");
endmodule // dfu_top

// [dfu_defines.svh]
// Constants of the digital I/O function unit: offsets, fields, timing.
// Assumes inclusion by bare name from the top-level design module.
`ifndef DFU_DEFINES_SVH
`define DFU_DEFINES_SVH
`define DFU_N_CH 6
`define DFU_ALM_W 32
`define DFU_CLK_PERIOD_NS 5
`define DFU_MS_NS 1000000
`define DFU_HOLD5_MS 5000
`define DFU_HOLD15_MS 15000
// Byte offsets of the global status and command words
`define DFU_STATUS_OFS 9'h000
`define DFU_CMD_OFS 9'h004
// Word index within a channel window (window c at 0x40*(c+1))
`define DFU_R_CFG 4'h0
`define DFU_R_SCALE 4'h1
`define DFU_R_PERIOD 4'h2
`define DFU_R_WIDTH 4'h3
`define DFU_R_MASK 4'h4
`define DFU_R_HOLDOFF 4'h5
`define DFU_R_SPLO 4'h6
`define DFU_R_SPHI 4'h7
`define DFU_R_SFMAP 4'h8
`define DFU_R_SFSEL 4'h9
`define DFU_R_STAT 4'ha
`define DFU_N_REGS 4'ha
// Configuration word fields
`define DFU_CFG_NC 3
`define DFU_CFG_LATCH 4
`define DFU_CFG_ALL 5
`define DFU_CFG_TLOW 6
`define DFU_CFG_SWITCH 7
// Command word: bits per channel, plus clear-all
`define DFU_CMD_ALL 8
`endif

// [dfu_pkg.sv]
// Types shared by the digital I/O function unit modules.
// Assumes nothing of its surroundings.
package dfu_pkg;
   typedef enum logic [2:0] {MODE_INPUT = 3'h0, MODE_SPECIAL = 3'h1, MODE_ACCUM = 3'h2, MODE_PERIODIC = 3'h3,
      MODE_ALARM = 3'h4, MODE_BELOW = 3'h5, MODE_ABOVE = 3'h6, MODE_RANGE = 3'h7} dfu_mode_e;
   typedef enum logic [3:0] {ACT_NONE = 4'h0, ACT_ADV = 4'h1, ACT_FLOW = 4'h2, ACT_PULSE = 4'h3,
      ACT_UNLATCH = 4'h4, ACT_ARCH_REL = 4'h5, ACT_ARCH_PUB = 4'h6, ACT_ARCH_PART = 4'h7,
      ACT_ALM_ACK = 4'h8, ACT_ABORT = 4'h9, ACT_PROG_RST = 4'ha} dfu_act_e;
   typedef enum logic [2:0] {PG_IDLE = 3'b001, PG_ON = 3'b010, PG_OFF = 3'b100} dfu_pgen_e;
   typedef struct packed {
      logic disp_adv; logic [1:0] flow_reset; logic [2:0] pulse_reset; logic [5:0] unlatch;
      logic arch_release; logic arch_publish; logic arch_partial; logic alarm_ack;
      logic prog_abort; logic prog_reset;
   } dfu_action_s;
   typedef struct packed {
      dfu_mode_e mode; logic nc; logic latch_en; logic all_mode;
      logic [15:0] width_ms; logic [15:0] period_ms; logic [15:0] holdoff_ms;
      logic [31:0] scale; logic [31:0] mask; logic signed [31:0] sp_lo; logic signed [31:0] sp_hi;
   } dfu_chcfg_s;
endpackage

// [dfu_pulse_gen.sv]
// Pulse generator of one channel: accumulated-count and periodic modes.
// Assumes a one-cycle millisecond tick on the same clock.
`timescale 1ns/1ps
module dfu_pulse_gen (
   input wire logic sys_clk,
   input wire logic resetn,
   input dfu_pkg::dfu_chcfg_s cfg,
   input wire logic ms_tick,
   input wire logic [31:0] accum_add,
   input wire logic accum_valid,
   output logic pulse,
   output logic [15:0] pending
);
   import dfu_pkg::*;
   dfu_pgen_e st_reg, st_next;
   logic [15:0] cnt_reg, cnt_next, pend_reg, pend_next;
   logic [31:0] acc_reg, acc_next;
   logic take;
   // Accumulate, and carve one scaling quantity per cycle off the sum
   wire logic is_acc = (cfg.mode == MODE_ACCUM);
   wire logic is_per = (cfg.mode == MODE_PERIODIC);
   wire logic [32:0] sum = {1'b0, acc_reg} + ((accum_valid && is_acc) ? {1'b0, accum_add} : 33'h0);
   wire logic ovf = is_acc && (cfg.scale != 32'h0) && (sum >= {1'b0, cfg.scale}) && (pend_reg != 16'hffff);
   wire logic want = is_per || (is_acc && pend_reg != 16'h0); // RQ10
   wire logic [15:0] gap = (is_per && cfg.period_ms > cfg.width_ms) ? cfg.period_ms - cfg.width_ms : cfg.width_ms;
   wire logic on_done = ms_tick && (cnt_reg + 16'h1 >= cfg.width_ms);
   wire logic off_done = ms_tick && (cnt_reg + 16'h1 >= gap);
   // Pulse sequencing; gaps equal the width in count mode
   always_comb begin
      st_next = st_reg;
      cnt_next = ms_tick ? cnt_reg + 16'h1 : cnt_reg;
      take = 1'b0;
      case (st_reg)
         PG_IDLE: if (want) begin
            st_next = PG_ON;
            cnt_next = 16'h0;
            take = is_acc;
         end
         PG_ON: if (on_done) begin
            st_next = PG_OFF;
            cnt_next = 16'h0;
         end
         PG_OFF: if (off_done) begin
            st_next = want ? PG_ON : PG_IDLE;
            cnt_next = 16'h0;
            take = want && is_acc;
         end
         default: st_next = PG_IDLE;
      endcase
      if (!(is_acc || is_per)) begin
         st_next = PG_IDLE;
      end
   end
   // Remainder and queue survive so no counted quantity is lost
   assign acc_next = !is_acc ? 32'h0 : (ovf ? sum[31:0] - cfg.scale : sum[31:0]); // RQ22
   assign pend_next = !is_acc ? 16'h0 : pend_reg + {15'h0, ovf} - {15'h0, take}; // RQ9
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= PG_IDLE;
         cnt_reg <= 16'h0;
         pend_reg <= 16'h0;
         acc_reg <= 32'h0;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         pend_reg <= pend_next;
         acc_reg <= acc_next;
      end
   end
   assign pulse = (st_reg == PG_ON);
   assign pending = pend_reg;
   chk_pulse_holds_on: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ10
      (st_reg == PG_ON) && !ms_tick && (is_acc || is_per) |=> (st_reg == PG_ON))
      else $error("pulse ended between millisecond ticks");
   chk_queue_keeps_count: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ22
      ovf && !take |=> pend_reg == $past(pend_reg) + 16'h1)
      else $error("accumulated pulse lost from queue");
endmodule // dfu_pulse_gen

// [dfu_alarm_cond.sv]
// Alarm and setpoint condition of one channel, with hold-off and latch.
// Assumes alarm flags and tracked value come from logic on the same clock.
`timescale 1ns/1ps
module dfu_alarm_cond (
   input wire logic sys_clk,
   input wire logic resetn,
   input dfu_pkg::dfu_chcfg_s cfg,
   input wire logic ms_tick,
   input wire logic [31:0] alarms,
   input wire logic signed [31:0] value,
   input wire logic clr,
   output logic active,
   output logic latched
);
   import dfu_pkg::*;
   logic [15:0] hold_reg;
   logic qual_reg, latch_reg;
   // Alarm selection, ANY or ALL
   wire logic [31:0] sel = alarms & cfg.mask; // RQ12
   wire logic alm_raw = cfg.all_mode ? (sel == cfg.mask && cfg.mask != 32'h0) : (sel != 32'h0); // RQ13
   wire logic below = value < cfg.sp_lo;
   wire logic above = value > cfg.sp_hi;
   wire logic is_alm = (cfg.mode == MODE_ALARM);
   wire logic cond_raw = (is_alm && alm_raw) || (cfg.mode == MODE_BELOW && below) || // RQ18
      (cfg.mode == MODE_ABOVE && above) || (cfg.mode == MODE_RANGE && (below || above));
   // Hold-off only gates alarm mode; it must persist unbroken
   wire logic qual_next = cond_raw && (!is_alm || hold_reg >= cfg.holdoff_ms); // RQ14
   // Set wins over a clear arriving in the same cycle
   wire logic latch_next = cfg.latch_en && (qual_next || (latch_reg && !clr)); // RQ15 RQ17
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hold_reg <= 16'h0;
         qual_reg <= 1'b0;
         latch_reg <= 1'b0;
      end else begin
         hold_reg <= !cond_raw ? 16'h0 : ((ms_tick && hold_reg != 16'hffff) ? hold_reg + 16'h1 : hold_reg);
         qual_reg <= qual_next;
         latch_reg <= latch_next;
      end
   end
   assign active = cfg.latch_en ? latch_reg : qual_reg; // RQ16
   assign latched = latch_reg; // RQ19
   chk_latch_holds_on: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ15
      latch_reg && cfg.latch_en && !clr |=> latch_reg)
      else $error("latched output dropped without clear");
   chk_holdoff_needs_cause: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ14
      is_alm && !cond_raw |=> !qual_reg)
      else $error("alarm output qualified without cause");
   chk_unlatched_drops: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ16
      !cfg.latch_en && !cond_raw |=> !active)
      else $error("unlatched output stayed active");
   chk_all_needs_every: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ13
      is_alm && cfg.all_mode && sel != cfg.mask |=> !qual_reg)
      else $error("ALL mode fired with an alarm missing");
endmodule // dfu_alarm_cond

// [dfu_field_switch.sv]
// Field contact model driving one special-function input.
// Assumes the bench calls press() from its own sequence.
`timescale 1ns/1ps
module dfu_field_switch (
   input wire logic sys_clk,
   output logic level
);
   // Contact rests open; a pull-down keeps the line low
   initial level = 1'b0;
   // Hold the contact closed for n clock cycles
   task automatic press(input int n);
      @(posedge sys_clk);
      level <= 1'b1;
      repeat (n) @(posedge sys_clk);
      level <= 1'b0;
   endtask
endmodule // dfu_field_switch

// [digital_io_function_unit_bench.sv]
// Bench of the digital I/O function unit: registers, special input, outputs.
// Assumes dfu_top with a 10-cycle millisecond to keep holds short.
`timescale 1ns/1ps
module digital_io_function_unit_bench;
   import dfu_pkg::*;
   logic sys_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, sw_pin;
   logic [8:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, rd_data, alarm_flags = '0;
   logic [5:0] chan_pin_out, chan_pin_oe, accum_valid = '0;
   logic [5:0][31:0] track_value = '0, accum_add = '0;
   logic [4:0] pin_hi = '0;
   logic [3:0] avs_byteenable = 4'hf;
   dfu_action_s actions, e;
   int n_fail = 0, check_count = 0;
   dfu_field_switch sw (.sys_clk(sys_clk), .level(sw_pin));
   dfu_top #(.CYC_PER_MS(10), .HOLD5_MS(16'h0005), .HOLD15_MS(16'h000f)) dut (.sys_clk(sys_clk),
      .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .chan_pin_in({pin_hi, sw_pin}), .chan_pin_out(chan_pin_out),
      .chan_pin_oe(chan_pin_oe), .alarm_flags(alarm_flags), .track_value(track_value),
      .accum_add(accum_add), .accum_valid(accum_valid), .actions(actions));
   // Clock
   initial forever #2.5 sys_clk = ~sys_clk;
   function automatic logic [8:0] ra(int c, int i);
      return 9'(64 * (c + 1) + 4 * i);
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // One bus cycle; held until waitrequest is seen low before the edge
   task automatic bus(logic w, logic [8:0] a, logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      forever begin
         @(negedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      @(posedge sys_clk);
      rd_data = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd(logic [8:0] a, logic [31:0] exp);
      bus(1'b0, a, '0);
      chk("readdata", rd_data, exp);
   endtask
   task automatic t_regs;
      rd(ra(0, 0), 32'h0);
      bus(1'b1, ra(0, 1), 32'h1234abcd);
      rd(ra(0, 1), 32'h1234abcd);
      avs_byteenable <= 4'h2;
      bus(1'b1, ra(0, 1), 32'h00005600);
      avs_byteenable <= 4'hf;
      rd(ra(0, 1), 32'h123456cd);
      // Low trigger inverts the level; a fitted switch forces high
      bus(1'b1, ra(5, 0), 32'h40);
      rd(9'h000, 32'h00200000);
      pin_hi <= 5'h10;
      bus(1'b1, ra(5, 0), 32'hc0);
      rd(9'h000, 32'h00200000);
      pin_hi <= 5'h00;
      rd(9'h004, 32'h0);
      rd(ra(0, 12), 32'h0);
      bus(1'b1, ra(0, 10), 32'hffffffff);
      rd(ra(0, 10), 32'h0);
      $display("registers done");
   endtask
   // Hold the switch, then expect one single-cycle action pulse
   task automatic press(int n, dfu_action_s x);
      int i;
      i = 0;
      sw.press(n);
      while (actions === '0 && i < 200) begin
         cyc(1);
         i++;
      end
      chk("actions", 32'(actions), 32'(x));
      cyc(1);
      chk("pulse end", 32'(actions), 32'h0);
   endtask
   task automatic t_special;
      bus(1'b1, ra(0, 0), 32'h1);
      bus(1'b1, ra(0, 8), 32'h421);
      bus(1'b1, ra(0, 9), 32'h83);
      e = '0;
      e.disp_adv = 1'b1;
      press(20, e);
      press(20, e);
      e = '0;
      e.flow_reset = 2'b11;
      press(70, e);
      e = '0;
      e.unlatch = 6'h04;
      press(170, e);
      bus(1'b1, ra(0, 8), 32'ha93);
      bus(1'b1, ra(0, 9), 32'h1c);
      e = '0;
      e.pulse_reset = 3'b111;
      press(20, e);
      e = '0;
      e.prog_abort = 1'b1;
      press(70, e);
      e = '0;
      e.prog_reset = 1'b1;
      press(170, e);
      bus(1'b1, ra(0, 8), 32'h876);
      e = '0;
      e.arch_publish = 1'b1;
      press(20, e);
      e = '0;
      e.arch_partial = 1'b1;
      press(70, e);
      e = '0;
      e.alarm_ack = 1'b1;
      press(170, e);
      $display("special input done");
   endtask
   task automatic t_alarm;
      bus(1'b1, ra(2, 4), 32'h3);
      bus(1'b1, ra(2, 0), 32'h34);
      alarm_flags <= 32'h1;
      cyc(6);
      chk("all one", 32'(chan_pin_out[2]), 32'h0);
      @(posedge sys_clk) alarm_flags <= 32'h3;
      cyc(6);
      chk("all set", 32'({chan_pin_oe[2], chan_pin_out[2]}), 32'h3);
      @(posedge sys_clk) alarm_flags <= 32'h0;
      cyc(6);
      chk("latched", 32'(chan_pin_out[2]), 32'h1);
      rd(9'h000, 32'h404);
      bus(1'b1, 9'h004, 32'h4);
      cyc(4);
      chk("cleared", 32'(chan_pin_out[2]), 32'h0);
      $display("alarm done");
   endtask
   task automatic t_cond;
      bus(1'b1, ra(1, 6), 32'd100);
      track_value[1] <= 32'd50;
      bus(1'b1, ra(1, 0), 32'h0d);
      cyc(4);
      chk("below nc", 32'(chan_pin_out[1]), 32'h0);
      @(posedge sys_clk) track_value[1] <= 32'd100;
      cyc(4);
      chk("normal nc", 32'(chan_pin_out[1]), 32'h1);
      $display("conditional done");
   endtask
   // 25 then 5 counts at scale 10: three pulses only if the remainder survives
   task automatic t_count;
      int n;
      logic last;
      n = 0;
      last = 1'b0;
      bus(1'b1, ra(3, 1), 32'd10);
      bus(1'b1, ra(3, 3), 32'd2);
      bus(1'b1, ra(3, 0), 32'h2);
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk) accum_add[3] <= k ? 32'd5 : 32'd25;
         accum_valid <= 6'h08;
         @(posedge sys_clk) accum_valid <= 6'h00;
         repeat (150) begin
            cyc(1);
            n += (chan_pin_out[3] && !last);
            last = chan_pin_out[3];
         end
      end
      chk("count pulses", n, 3);
      rd(ra(3, 10), 32'h0);
      $display("count output done");
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog: tests need well under 20000 cycles
   initial begin
      #100000;
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      t_regs();
      t_special();
      t_alarm();
      t_cond();
      t_count();
      complete_run();
   end
endmodule // digital_io_function_unit_bench
